/* File: logic/ssp_pkg.sv */
// constants, register map and types for the synchronous serial port
// ============================================================
package ssp_pkg;

  // ============================================================
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL0  = 8'h00; // control_register_zero
  localparam logic [7:0] ADDR_CTRL1  = 8'h04; // enable, slave select
  localparam logic [7:0] ADDR_DATA   = 8'h08; // data_port_register
  localparam logic [7:0] ADDR_STAT   = 8'h0c; // store levels, busy
  localparam logic [7:0] ADDR_PSC    = 8'h10; // prescale_register
  localparam logic [7:0] ADDR_IMASK  = 8'h14; // interrupt_mask_register
  localparam logic [7:0] ADDR_RAW    = 8'h18; // raw_interrupt_status
  localparam logic [7:0] ADDR_MASKED = 8'h1c; // masked_interrupt_status
  localparam logic [7:0] ADDR_ICLR   = 8'h20; // interrupt_clear_register
  localparam logic [7:0] ADDR_DMAC   = 8'h24; // dma_control_register
  localparam logic [7:0] ADDR_GATE   = 8'h28; // run_clock_gate_register

  // ============================================================
  // field positions
  localparam int CR0_FMT  = 4;  // 0 select format, 1 framed format
  localparam int CR0_CPOL = 6;  // idle level of the bit clock
  localparam int CR0_SCR  = 8;  // bit_rate_divide_field, 8 bits
  localparam int CR1_EN   = 0;
  localparam int CR1_SLV  = 1;
  localparam int IRQ_OVR  = 0;
  localparam int IRQ_RTO  = 1;
  localparam int IRQ_RXS  = 2;
  localparam int IRQ_TXS  = 3;
  localparam int IRQ_EOT  = 4;
  localparam int DMA_RX   = 0;
  localparam int DMA_TX   = 1;

  // ============================================================
  // reset values and limits
  localparam logic [15:0] CR0_RESET  = 16'h0007;
  localparam logic [7:0]  PSC_MIN    = 8'h02;
  localparam logic [3:0]  DSS_MIN    = 4'h3;   // four-bit frames
  localparam logic [3:0]  FIFO_HALF  = 4'h4;
  localparam logic [3:0]  FIFO_FULL  = 4'h8;
  localparam logic [5:0]  RT_BITS    = 6'h20;  // 32 bit periods

  typedef enum logic [0:0] {SSP_IDLE, SSP_XFER} ssp_state_e;

endpackage : ssp_pkg

/* File: logic/ssp_top.sv */
// synchronous serial port: register file, stores, clock divider, shifter
`timescale 1ns/100ps
module ssp_top
  import ssp_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [7:0]  addr,
  input  wire logic [15:0] wr_data,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic      [15:0] rd_data,
  input  wire logic        serial_in_pin,
  input  wire logic        serial_clk_in,
  input  wire logic        frame_sel_in,
  output logic             serial_out_pin,
  output logic             serial_out_oe,
  output logic             serial_bit_clock,
  output logic             serial_clk_oe,
  output logic             frame_sel_out,
  output logic             irq,
  output logic             tx_dma_req,
  output logic             rx_dma_req
);

  // ============================================================
  // state
  typedef struct packed {
    logic [15:0]       cr0;
    logic [1:0]        cr1;
    logic [7:0]        psc;
    logic [4:0]        imask;
    logic [1:0]        dmac;
    logic              gate;
    logic [7:0][15:0]  txm;
    logic [2:0]        tx_wp;
    logic [2:0]        tx_rp;
    logic [3:0]        tx_cnt;
    logic [7:0][15:0]  rxm;
    logic [2:0]        rx_wp;
    logic [2:0]        rx_rp;
    logic [3:0]        rx_cnt;
    logic [15:0]       div_cnt;
    logic              half_tick;
    logic              tphase;
    logic [5:0]        rt_cnt;
    logic [2:0]        stk;      // eot, timeout, overrun
    ssp_state_e        st;
    logic              mst;      // transfer driven by our own clock
    logic [15:0]       sh_tx;
    logic [15:0]       sh_rx;
    logic [3:0]        bit_cnt;
    logic              half;
    logic              skip;
    logic              sclk_prev;
    logic              sel_prev;
    logic              sclk;
    logic              sclk_oe;
    logic              frm;
    logic              txd;
    logic              txd_oe;
    logic [15:0]       rd_data;
    logic              irq;
    logic              tx_dma;
    logic              rx_dma;
  } ssp_state_s;

  ssp_state_s r_reg;
  ssp_state_s r_next;

  // ============================================================
  // outputs straight from the state register
  assign rd_data          = r_reg.rd_data;
  assign serial_out_pin   = r_reg.txd;
  assign serial_out_oe    = r_reg.txd_oe;
  assign serial_bit_clock = r_reg.sclk;
  assign serial_clk_oe    = r_reg.sclk_oe;
  assign frame_sel_out    = r_reg.frm;
  assign irq              = r_reg.irq;
  assign tx_dma_req       = r_reg.tx_dma;
  assign rx_dma_req       = r_reg.rx_dma;

  // ============================================================
  // next-state logic
  always_comb begin : p_next
    logic [3:0]  dss;
    logic        ssf;
    logic        cpol;
    logic        en;
    logic        slv;
    logic [15:0] half_len;
    logic        bit_tick;
    logic        lead;
    logic        trail;
    logic        lv;
    logic        pv;
    logic        tx_push;
    logic        tx_pop;
    logic        rx_pop;
    logic        rx_req;
    logic        rx_push;
    logic        word_done;
    logic        do_load;
    logic [15:0] word;
    logic [15:0] shifted;
    logic [2:0]  set_v;
    logic [2:0]  clr_v;
    logic [4:0]  raw;
    logic [7:0]  psc_w;

    n_init();
    dss       = (r_reg.cr0[3:0] < DSS_MIN) ? DSS_MIN : r_reg.cr0[3:0];
    ssf       = r_reg.cr0[CR0_FMT];
    cpol      = r_reg.cr0[CR0_CPOL];
    en        = r_reg.cr1[CR1_EN] & r_reg.gate;
    slv       = r_reg.cr1[CR1_SLV];
    // half period: prescale/2 times (1 + rate field)
    half_len  = 16'({9'h000, r_reg.psc[7:1]} *
                    ({1'b0, r_reg.cr0[CR0_SCR +: 8]} + 9'h001));
    bit_tick  = r_reg.half_tick & r_reg.tphase;
    lv        = serial_clk_in ^ cpol;
    pv        = r_reg.sclk_prev ^ cpol;
    lead      = 1'b0;
    trail     = 1'b0;
    tx_push   = 1'b0;
    tx_pop    = 1'b0;
    rx_pop    = 1'b0;
    rx_req    = 1'b0;
    rx_push   = 1'b0;
    word_done = 1'b0;
    do_load   = 1'b0;
    word      = 16'h0000;
    shifted   = r_reg.sh_tx << 1;
    set_v     = 3'b000;
    clr_v     = 3'b000;
    psc_w     = {wr_data[7:1], 1'b0};
    raw       = 5'b00000;

    // divider runs always so the timeout counts even with the link idle
    if (r_reg.div_cnt == 16'h0000) begin
      r_next.div_cnt   = half_len - 16'h0001;
      r_next.half_tick = 1'b1;
    end else begin
      r_next.div_cnt   = r_reg.div_cnt - 16'h0001;
      r_next.half_tick = 1'b0;
    end
    if (r_reg.half_tick) begin
      r_next.tphase = ~r_reg.tphase;
    end
    r_next.sclk_prev = serial_clk_in;
    r_next.sel_prev  = frame_sel_in;

    // ------------------------------------------------------------
    // register writes
    if (wr_stb) begin
      unique case (addr)
        ADDR_CTRL0: r_next.cr0 = wr_data;
        ADDR_CTRL1: r_next.cr1 = wr_data[1:0];
        ADDR_DATA:  tx_push = (r_reg.tx_cnt != FIFO_FULL) & r_reg.gate;
        ADDR_PSC:   r_next.psc = (psc_w < PSC_MIN) ? PSC_MIN : psc_w;
        ADDR_IMASK: r_next.imask = wr_data[4:0];
        ADDR_ICLR:  clr_v = {wr_data[IRQ_EOT], wr_data[IRQ_RTO],
                             wr_data[IRQ_OVR]};
        ADDR_DMAC:  r_next.dmac = wr_data[1:0];
        ADDR_GATE:  r_next.gate = wr_data[0];
        default:    ; // unmapped writes are ignored
      endcase
    end

    // ------------------------------------------------------------
    // transfer engine
    if (r_reg.mst) begin
      lead  = r_reg.half_tick & ~r_reg.half;
      trail = r_reg.half_tick & r_reg.half;
    end else begin
      lead  = lv & ~pv;
      trail = ~lv & pv;
    end

    unique case (r_reg.st)
      SSP_IDLE: begin
        r_next.mst     = ~slv;
        r_next.sclk    = cpol;
        r_next.sclk_oe = en & ~slv;
        r_next.frm     = ~ssf;           // select high, frame low
        r_next.txd_oe  = en & ~slv;
        if (en & ~slv & r_reg.half_tick & (r_reg.tx_cnt != 4'h0)) begin
          do_load     = 1'b1;
          r_next.frm  = ssf;             // frame pulse or select low
        end else if (en & slv) begin
          // remote master opens a word: select falls or frame rises
          if (ssf ? (frame_sel_in & ~r_reg.sel_prev)
                  : (~frame_sel_in & r_reg.sel_prev)) begin
            do_load = 1'b1;
          end
        end
      end
      SSP_XFER: begin
        if (lead) begin
          if (r_reg.mst) begin
            r_next.sclk = ~cpol;
          end
          if (!r_reg.skip) begin
            r_next.sh_rx = {r_reg.sh_rx[14:0], serial_in_pin};
          end
          r_next.half = 1'b1;
        end
        if (trail) begin
          r_next.half = 1'b0;
          if (r_reg.mst) begin
            r_next.sclk = cpol;
          end
          if (r_reg.skip) begin
            // framed format: pulse bit over, msb goes out now
            r_next.skip = 1'b0;
            if (r_reg.mst) begin
              r_next.frm = 1'b0;
            end
            r_next.txd  = r_reg.sh_tx[dss];
          end else if (r_reg.bit_cnt == 4'h0) begin
            word_done = 1'b1;
          end else begin
            r_next.sh_tx   = shifted;
            r_next.txd     = shifted[dss];
            r_next.bit_cnt = r_reg.bit_cnt - 4'h1;
          end
        end
        if (word_done) begin
          rx_req = 1'b1;
          if (r_reg.tx_cnt == 4'h0) begin
            set_v[2] = 1'b1;
          end
          if (!r_reg.mst && !ssf && !frame_sel_in) begin
            do_load = 1'b1;              // select held: next word
          end else begin
            r_next.st  = SSP_IDLE;
            r_next.frm = ~ssf;
          end
        end
        // remote master released select mid word: drop the word
        if (!r_reg.mst && !ssf && frame_sel_in) begin
          r_next.st     = SSP_IDLE;
          r_next.txd_oe = 1'b0;
        end
        if (!en) begin
          r_next.st = SSP_IDLE;
        end
      end
      default: r_next.st = SSP_IDLE;
    endcase

    // load a word: queued one, or in slave mode the eighth-last write
    if (do_load) begin
      if (r_reg.tx_cnt != 4'h0) begin
        word   = r_reg.txm[r_reg.tx_rp];
        tx_pop = 1'b1;
      end else begin
        word   = r_reg.txm[r_reg.tx_wp];
      end
      r_next.st      = SSP_XFER;
      r_next.sh_tx   = word;
      r_next.sh_rx   = 16'h0000;
      r_next.txd     = ssf ? 1'b0 : word[dss];
      r_next.txd_oe  = 1'b1;
      r_next.bit_cnt = dss;
      r_next.skip    = ssf;
      r_next.half    = 1'b0;
    end

    // ------------------------------------------------------------
    // register reads; a data read pops the receive store
    r_next.rd_data = 16'h0000;
    raw[IRQ_OVR] = r_reg.stk[0];
    raw[IRQ_RTO] = r_reg.stk[1];
    raw[IRQ_RXS] = r_reg.rx_cnt >= FIFO_HALF;
    raw[IRQ_TXS] = r_reg.tx_cnt <= FIFO_HALF;
    raw[IRQ_EOT] = r_reg.stk[2];
    if (rd_stb) begin
      unique case (addr)
        ADDR_CTRL0:  r_next.rd_data = r_reg.cr0;
        ADDR_CTRL1:  r_next.rd_data = {14'h0000, r_reg.cr1};
        ADDR_DATA: begin
          if (r_reg.rx_cnt != 4'h0) begin
            r_next.rd_data = r_reg.rxm[r_reg.rx_rp];
            rx_pop = 1'b1;
          end
        end
        ADDR_STAT: r_next.rd_data = {11'h000,
                                     r_reg.st == SSP_XFER,
                                     r_reg.rx_cnt == FIFO_FULL,
                                     r_reg.rx_cnt != 4'h0,
                                     r_reg.tx_cnt != FIFO_FULL,
                                     r_reg.tx_cnt == 4'h0};
        ADDR_PSC:    r_next.rd_data = {8'h00, r_reg.psc};
        ADDR_IMASK:  r_next.rd_data = {11'h000, r_reg.imask};
        ADDR_RAW:    r_next.rd_data = {11'h000, raw};
        ADDR_MASKED: r_next.rd_data = {11'h000, raw & r_reg.imask};
        ADDR_DMAC:   r_next.rd_data = {14'h0000, r_reg.dmac};
        ADDR_GATE:   r_next.rd_data = {15'h0000, r_reg.gate};
        default:     r_next.rd_data = 16'h0000;
      endcase
    end

    // ------------------------------------------------------------
    // stores; the finished word is already registered in sh_rx
    rx_push = rx_req & (r_reg.rx_cnt != FIFO_FULL);
    set_v[0] = rx_req & (r_reg.rx_cnt == FIFO_FULL);
    if (tx_push) begin
      r_next.txm[r_reg.tx_wp] = wr_data;
      r_next.tx_wp = r_reg.tx_wp + 3'h1;
    end
    if (tx_pop) begin
      r_next.tx_rp = r_reg.tx_rp + 3'h1;
    end
    r_next.tx_cnt = r_reg.tx_cnt + {3'h0, tx_push} - {3'h0, tx_pop};
    if (rx_push) begin
      r_next.rxm[r_reg.rx_wp] = r_reg.sh_rx;
      r_next.rx_wp = r_reg.rx_wp + 3'h1;
    end
    if (rx_pop) begin
      r_next.rx_rp = r_reg.rx_rp + 3'h1;
    end
    r_next.rx_cnt = r_reg.rx_cnt + {3'h0, rx_push} - {3'h0, rx_pop};

    // ------------------------------------------------------------
    // receive timeout counts bit periods while data waits
    if (r_reg.rx_cnt == 4'h0) begin
      r_next.rt_cnt = 6'h00;
    end else if (bit_tick && r_reg.rt_cnt != RT_BITS) begin
      r_next.rt_cnt = r_reg.rt_cnt + 6'h01;
      set_v[1] = (r_reg.rt_cnt + 6'h01) == RT_BITS;
    end

    // a set in the same cycle as a clear wins
    r_next.stk = (r_reg.stk & ~clr_v) | set_v;

    // ------------------------------------------------------------
    // interrupt and dma outputs, one cycle behind the sources
    r_next.irq    = |(raw & r_reg.imask);
    r_next.tx_dma = r_reg.dmac[DMA_TX] & raw[IRQ_TXS];
    r_next.rx_dma = r_reg.dmac[DMA_RX] & raw[IRQ_RXS];

    // closed clock gate: stores and history wiped so resends are zero
    if (!r_reg.gate) begin
      r_next.txm    = '0;
      r_next.tx_wp  = 3'h0;
      r_next.tx_rp  = 3'h0;
      r_next.tx_cnt = 4'h0;
      r_next.rxm    = '0;
      r_next.rx_wp  = 3'h0;
      r_next.rx_rp  = 3'h0;
      r_next.rx_cnt = 4'h0;
      r_next.rt_cnt = 6'h00;
    end
  end

  // copy of the current state as the default next state
  function automatic void n_init();
    r_next = r_reg;
  endfunction : n_init

  // ============================================================
  // state register; synchronous reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      r_reg         <= '0;
      r_reg.cr0     <= CR0_RESET;
      r_reg.psc     <= PSC_MIN;
      r_reg.st      <= SSP_IDLE;
      r_reg.frm     <= 1'b1;             // select inactive high
      r_reg.mst     <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

endmodule : ssp_top

/* File: tb/ssp_monitor.sv */
// concurrent checks on the serial port top-level ports
`timescale 1ns/100ps
module ssp_monitor
  import ssp_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic [7:0]  addr,
  input wire logic        rd_stb,
  input wire logic [15:0] rd_data,
  input wire logic        serial_out_pin,
  input wire logic        serial_bit_clock,
  input wire logic        serial_clk_oe,
  input wire logic        frame_sel_out,
  input wire logic        irq,
  input wire logic        tx_dma_req,
  input wire logic        rx_dma_req
);
  // ============================================================
  // one clock domain, so one default clocking
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // ============================================================
  // register answers
  a_rd_quiet: assert property (!$past(rd_stb) |-> rd_data == 16'h0000)
    else $error("read data not zero outside a read answer");
  a_unmapped_zero: assert property (
    $past(rd_stb) && $past(addr) >= 8'h2c |-> rd_data == 16'h0000)
    else $error("unmapped read returned data");
  // irq is one cycle behind, as is the masked read answer
  a_irq_or: assert property (
    $past(rd_stb) && $past(addr) == ADDR_MASKED |->
    irq == (rd_data[4:0] != 5'h00))
    else $error("combined interrupt disagrees with masked status");
  a_reset_state: assert property ($fell(rst) |-> !irq &&
    !tx_dma_req && !rx_dma_req && frame_sel_out && !serial_clk_oe)
    else $error("outputs not quiet after reset");

  // ============================================================
  // serial link shape
  a_clk_idle: assert property (
    frame_sel_out [*3] |-> $stable(serial_bit_clock))
    else $error("bit clock moved while idle");
  a_clk_start: assert property (
    $fell(frame_sel_out) |-> $stable(serial_bit_clock))
    else $error("bit clock not at rest when a word starts");
  a_bit_edge: assert property (
    !frame_sel_out && !$past(frame_sel_out) &&
    $changed(serial_out_pin) |-> $changed(serial_bit_clock))
    else $error("data changed away from a clock edge");
  a_sel_gap: assert property ($rose(frame_sel_out) |=> frame_sel_out)
    else $error("select too short between words");

  // main scenarios
  c_irq: cover property ($rose(irq));
  c_word: cover property ($fell(frame_sel_out));
  c_rx_dma: cover property ($rose(rx_dma_req));
endmodule : ssp_monitor

bind ssp_top ssp_monitor u_mon (.mclk, .rst, .addr, .rd_stb, .rd_data,
  .serial_out_pin, .serial_bit_clock, .serial_clk_oe, .frame_sel_out, .irq,
  .tx_dma_req, .rx_dma_req);

/* File: tb/ssp_slave_model.sv */
// far-side serial device answering the port in master mode
`timescale 1ns/100ps
module ssp_slave_model (
  input  wire logic       sclk,
  input  wire logic       sel_n,
  input  wire logic       mosi,
  output logic            miso,
  output logic [7:0]      got,
  output logic [7:0]      sent
);
  logic [7:0] sh;

  initial begin
    miso = 1'b0;
    got = 8'h00;
    sent = 8'h00;
    sh = 8'h00;
  end
  // a fresh word each select, msb first
  always @(negedge sel_n) begin
    sent = 8'($urandom);
    sh = sent;
    miso = sent[7];
  end
  // leading edge samples
  always @(posedge sclk) if (!sel_n) got = {got[6:0], mosi};
  // trailing edge shifts
  always @(negedge sclk) if (!sel_n) begin
    sh = {sh[6:0], 1'b0};
    miso = sh[7];
  end
  // released line shows the inverse, not a stale bit
  always @(posedge sel_n) miso = ~miso;
endmodule : ssp_slave_model

/* File: tb/tb.sv */
// self-checking bench for the synchronous serial port
`timescale 1ns/100ps
module tb
  import ssp_pkg::*;
();
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [15:0] wr_data = 16'h0000;
  logic        wr_stb = 1'b0;
  logic        rd_stb = 1'b0;
  logic        sin_tb = 1'b0;
  logic        serial_clk_in = 1'b0;
  logic        frame_sel_in = 1'b1;
  logic        slv = 1'b0;
  logic        mst = 1'b0;
  logic [15:0] rd_data;
  logic        sout, sout_oe, sclk, sclk_oe, fso, irq, txd, rxd, miso;
  logic [7:0]  got, sent;
  logic [7:0]  hi_cnt = 8'h00;
  logic [7:0]  last_hi = 8'h00;
  logic [15:0] d;
  logic [15:0] txq[$], rxq[$], wlog[$];
  int          n_errors = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          frames = 0;
  wire         serial_in_pin = slv ? sin_tb : miso;
  localparam logic [15:0] PW[3] = '{16'h0003, 16'h0000, 16'h00ff};
  localparam logic [15:0] PE[3] = '{16'h0002, 16'h0002, 16'h00fe};

  always #4 mclk = ~mclk;

  ssp_top dut (.mclk(mclk), .rst(rst), .addr(addr), .wr_data(wr_data),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
    .serial_in_pin(serial_in_pin), .serial_clk_in(serial_clk_in),
    .frame_sel_in(frame_sel_in), .serial_out_pin(sout),
    .serial_out_oe(sout_oe), .serial_bit_clock(sclk),
    .serial_clk_oe(sclk_oe), .frame_sel_out(fso), .irq(irq),
    .tx_dma_req(txd), .rx_dma_req(rxd));
  ssp_slave_model u_far (.sclk(sclk), .sel_n(fso), .mosi(sout),
    .miso(miso), .got(got), .sent(sent));

  // ============================================================
  // bus, compare and model helpers
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] w);
    @(posedge mclk);
    addr <= a;
    wr_data <= w;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] r);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1 r = rd_data;
  endtask : rd
  // full store refuses, so the model drops the word too
  task automatic dwr(input logic [7:0] w);
    wr(ADDR_DATA, {8'h00, w});
    if (txq.size() < 8) begin
      txq.push_back({8'h00, w});
      wlog.push_back({8'h00, w});
    end
  endtask : dwr
  function automatic void push_rx(input logic [15:0] w);
    if (rxq.size() < 8) rxq.push_back(w);
  endfunction : push_rx
  task automatic wait_frames(input int n);
    for (int i = 0; i < 5000 && frames < n; i++) @(posedge mclk);
    chk("frames", n[15:0], frames[15:0]);
  endtask : wait_frames
  task automatic drain();
    while (rxq.size() > 0) begin
      rd(ADDR_RAW, d);
      chk("rx svc", {13'h0, rxq.size() >= 4, 2'b0}, d & 16'h0004);
      rd(ADDR_DATA, d);
      chk("rx word", rxq.pop_front(), d);
    end
    rd(ADDR_DATA, d);
    chk("rx empty", 16'h0000, d);
  endtask : drain
  // remote master, 16 mclk per bit keeps under a twelfth
  task automatic sxfer(input logic [7:0] m);
    logic [15:0] e;
    logic [7:0]  s;
    if (txq.size() > 0) e = txq.pop_front();
    else if (wlog.size() < 8) e = 16'h0000;
    else e = wlog[wlog.size() - 8];
    @(posedge mclk);
    frame_sel_in <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      sin_tb <= m[i];
      repeat (8) @(posedge mclk);
      s[i] = sout;
      if (i == 7) begin
        chk("slave oe", 16'h0001, {14'h0, sclk_oe, sout_oe});
      end
      serial_clk_in <= 1'b1;
      repeat (8) @(posedge mclk);
      // select rises with the last falling clock, else a held select reloads
      if (i == 0) frame_sel_in <= 1'b1;
      serial_clk_in <= 1'b0;
    end
    repeat (8) @(posedge mclk);
    sin_tb <= ~m[0];
    repeat (16) @(posedge mclk);
    chk("slave out", e, {8'h00, s});
    chk("slave oe off", 16'h0000, {14'h0, sclk_oe, sout_oe});
    push_rx({8'h00, m});
  endtask : sxfer
  task automatic final_report();
    if (n_errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report

  // ============================================================
  // watchers: master words, clock high time, hang limit
  always @(posedge fso) if (mst) begin
    frames++;
    chk("mosi", txq.pop_front(), {8'h00, got});
    push_rx({8'h00, sent});
  end
  always @(posedge mclk) begin
    if (sclk) hi_cnt <= hi_cnt + 8'h01;
    else hi_cnt <= 8'h00;
    if (!sclk && hi_cnt != 8'h00) last_hi <= hi_cnt;
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      final_report();
    end
  end

  // ============================================================
  // main sequence
  initial begin
    void'($urandom(32'h848f_7806));
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    rd(ADDR_CTRL0, d);
    chk("ctrl0 rst", CR0_RESET, d);
    rd(ADDR_RAW, d);
    chk("raw rst", 16'h0008, d);
    rd(8'h30, d);
    chk("unmapped", 16'h0000, d);
    foreach (PW[i]) begin
      wr(ADDR_PSC, PW[i]);
      rd(ADDR_PSC, d);
      chk("psc", PE[i], d);
    end
    // odd 5 becomes 4, rate 1: half period 4, 15.6 MHz bit clock
    wr(ADDR_GATE, 16'h0001);
    wr(ADDR_PSC, 16'h0005);
    wr(ADDR_CTRL0, 16'h0107);
    wr(ADDR_IMASK, 16'h001f);
    mst = 1'b1;
    for (int i = 0; i < 9; i++) dwr(8'($urandom));
    rd(ADDR_STAT, d);
    chk("stat full", 16'h0000, d & 16'h000f);
    wr(ADDR_CTRL1, 16'h0001);
    wait_frames(8);
    chk("half period", 16'h0004, {8'h00, last_hi});
    chk("oe master", 16'h0003, {14'h0, sclk_oe, sout_oe});
    dwr(8'($urandom));
    wait_frames(9);
    rd(ADDR_RAW, d);
    chk("raw all", 16'h001f, d);
    chk("irq on", 16'h0001, {15'h0, irq});
    wr(ADDR_IMASK, 16'h0000);
    rd(ADDR_MASKED, d);
    chk("masked", 16'h0000, d);
    chk("irq off", 16'h0000, {15'h0, irq});
    wr(ADDR_IMASK, 16'h0004);
    rd(ADDR_MASKED, d);
    chk("masked", 16'h0004, d);
    chk("irq rx", 16'h0001, {15'h0, irq});
    wr(ADDR_DMAC, 16'h0003);
    repeat (2) @(posedge mclk);
    #1 chk("dma on", 16'h0003, {14'h0, txd, rxd});
    wr(ADDR_DMAC, 16'h0000);
    repeat (2) @(posedge mclk);
    #1 chk("dma off", 16'h0000, {14'h0, txd, rxd});
    wr(ADDR_ICLR, 16'h0000);
    rd(ADDR_RAW, d);
    chk("clear zero", 16'h001f, d);
    drain();
    wr(ADDR_ICLR, 16'h0013);
    rd(ADDR_RAW, d);
    chk("cleared", 16'h0008, d);
    chk("irq clr", 16'h0000, {15'h0, irq});
    // slave: gate cycling wipes history, so empty sends zero
    mst = 1'b0;
    slv <= 1'b1;
    wr(ADDR_GATE, 16'h0000);
    wr(ADDR_GATE, 16'h0001);
    txq.delete();
    wlog.delete();
    wr(ADDR_CTRL1, 16'h0003);
    sxfer(8'($urandom));
    // 32 bit periods of 8 mclk from the first received word
    repeat (200) @(posedge mclk);
    rd(ADDR_RAW, d);
    chk("rto early", 16'h0000, d & 16'h0002);
    repeat (50) @(posedge mclk);
    rd(ADDR_RAW, d);
    chk("rto set", 16'h0002, d & 16'h0002);
    for (int k = 0; k < 8; k++) begin
      dwr(8'($urandom));
      rd(ADDR_RAW, d);
      chk("tx svc", {12'h0, txq.size() <= 4, 3'b0}, d & 16'h0008);
    end
    for (int k = 0; k < 9; k++) sxfer(8'($urandom));
    drain();
    final_report();
  end
endmodule : tb
